// >>> hw/dasr_map.svh
// Constants of the dual ADC serial readout: frame layout, windows, timing
`ifndef DASR_MAP_SVH
`define DASR_MAP_SVH

`define DASR_RES_W         12
`define DASR_CNT_W         6
`define DASR_RX_W          32
`define DASR_LEAD_ZEROS    2
`define DASR_MIN_EDGES     14
`define DASR_LONG_EDGES    16
`define DASR_TRACK_EDGE    13
`define DASR_DUAL_END      32
`define DASR_PD_LO         2
`define DASR_PD_HI         10

`define DASR_SYS_MHZ       200
`define DASR_SCLK_PERIOD_NS 160
`define DASR_FULL_WAKE_NS  1500000
`define DASR_PART_WAKE_NS  1000
`define DASR_PART_DWELL_NS 67000
`define DASR_QUIET_CYC     8

// Least times round up to whole sys_clk cycles
`define DASR_NS_TO_CYC(ns) ((((ns) * `DASR_SYS_MHZ) + 999) / 1000)
`define DASR_SCLK_HALF_CYC ((`DASR_SCLK_PERIOD_NS * `DASR_SYS_MHZ) / 2000)

`endif

// >>> hw/dasr_pkg.sv
// Types for the two ends of the dual ADC serial readout; each type is used by one end only
`include "dasr_map.svh"
package dasr_pkg;

  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_PARTIAL,
    PWR_FULL
  } dasr_pwr_t;

  typedef enum logic [1:0] {
    WAKE_NONE,
    WAKE_PARTIAL,
    WAKE_FULL
  } dasr_wake_t;

  typedef enum logic [1:0] {
    H_IDLE,
    H_RUN,
    H_TAIL,
    H_QUIET
  } dasr_hst_t;

  typedef struct packed {
    logic [`DASR_CNT_W-1:0] cnt;
    logic                   dout_first;
    logic                   dout_second;
    logic                   ended;
  } dasr_frame_t;

  typedef struct packed {
    logic [`DASR_RES_W-1:0] word_first;
    logic [`DASR_RES_W-1:0] word_second;
    logic                   valid;
    logic                   flip;
  } dasr_hold_t;

  typedef struct packed {
    dasr_pwr_t pwr_s1;
    dasr_pwr_t pwr_s2;
    dasr_pwr_t pwr_s3;
    dasr_pwr_t power_state;
    logic [2:0] tog;
    logic       tog_seen;
    logic       sample_taken;
  } dasr_sys_t;

  typedef struct packed {
    dasr_hst_t              st;
    logic [7:0]             div;
    logic [`DASR_CNT_W-1:0] edge_n;
    logic [`DASR_CNT_W-1:0] target;
    logic [19:0]            wake_cnt;
    logic [15:0]            dwell;
    logic                   sclk;
    logic                   cs_b;
    logic [2:0]             sa;
    logic [2:0]             sb;
    logic                   a_val;
    logic                   b_val;
    logic [`DASR_RX_W-1:0]  rx_a;
    logic [`DASR_RX_W-1:0]  rx_b;
    logic [`DASR_RX_W-1:0]  word_a;
    logic [`DASR_RX_W-1:0]  word_b;
    logic                   ready;
    logic                   done;
    logic                   primed;
  } dasr_host_t;

endpackage

// >>> hw/dasr_link_if.sv
// Link between the host controller and the dual-channel ADC
`timescale 1ns/1ps
interface dasr_link_if;
  logic cs_b;
  logic adc_serial_clock;
  logic first_o;
  logic first_oe;
  logic second_o;
  logic second_oe;
  logic data_out_first;
  logic data_out_second;

  // Released lines are pulled high
  assign data_out_first  = first_oe ? first_o : 1'b1;
  assign data_out_second = second_oe ? second_o : 1'b1;

  modport adc (
    input  cs_b,
    input  adc_serial_clock,
    output first_o,
    output first_oe,
    output second_o,
    output second_oe
  );

  modport host (
    output cs_b,
    output adc_serial_clock,
    input  data_out_first,
    input  data_out_second
  );
endinterface

// >>> hw/dasr_adc.sv
// Device end: dual-channel ADC serial readout and power-state sequencing
`timescale 1ns/1ps
`include "dasr_map.svh"
module dasr_adc #(
  parameter int FRAME_CLKS = `DASR_LONG_EDGES
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  dasr_link_if.adc                    link,
  input  wire logic [`DASR_RES_W-1:0] analog_first,
  input  wire logic [`DASR_RES_W-1:0] analog_second,
  output dasr_pkg::dasr_pwr_t         power_state,
  output logic                        sampler_hold,
  output logic                        sample_taken
);
  import dasr_pkg::*;

  localparam logic [`DASR_CNT_W-1:0] SECOND_START =
    `DASR_CNT_W'(FRAME_CLKS);
  localparam logic [`DASR_CNT_W-1:0] LAST_EDGE =
    `DASR_CNT_W'(`DASR_DUAL_END);
  localparam logic [`DASR_CNT_W-1:0] TRACK_EDGE =
    `DASR_CNT_W'(`DASR_TRACK_EDGE);
  localparam logic [`DASR_CNT_W-1:0] LEAD =
    `DASR_CNT_W'(`DASR_LEAD_ZEROS);
  localparam logic [`DASR_CNT_W-1:0] BODY_END =
    `DASR_CNT_W'(`DASR_MIN_EDGES);
  localparam logic [`DASR_CNT_W-1:0] PD_LO =
    `DASR_CNT_W'(`DASR_PD_LO);
  localparam logic [`DASR_CNT_W-1:0] PD_HI =
    `DASR_CNT_W'(`DASR_PD_HI);

  dasr_frame_t frame;
  dasr_frame_t next_frame;
  dasr_hold_t  hold;
  dasr_pwr_t   pwr;
  dasr_pwr_t   next_pwr;
  dasr_sys_t   sys;
  dasr_sys_t   next_sys;
  logic        frame_clr;
  logic        track;

  // Frame logic is cleared whenever select is high or under reset
  assign frame_clr = link.cs_b | ~rst_b;

  // Bit on a line after n falling edges; the line's own result first
  function automatic logic frame_bit(
    input logic [`DASR_CNT_W-1:0] n,
    input logic [`DASR_RES_W-1:0] w_own,
    input logic [`DASR_RES_W-1:0] w_other
  );
    logic [`DASR_CNT_W-1:0] m;
    logic [`DASR_RES_W-1:0] w;
    logic [3:0]             idx;
    m = n;
    w = w_own;
    if (n >= SECOND_START) begin
      m = n - SECOND_START;
      w = w_other;
    end
    idx = 4'(BODY_END - 6'h01 - m);
    frame_bit = 1'b0;
    if (m >= LEAD && m < BODY_END) begin
      frame_bit = w[idx];
    end
  endfunction

  // Hold capture on the select fall; a powered-down dummy frame
  // shifts zeros since the analog side is still waking
  always_ff @(negedge link.cs_b or negedge rst_b) begin
    if (!rst_b) begin
      hold <= '0;
    end else begin
      hold.word_first  <= analog_first;
      hold.word_second <= analog_second;
      hold.valid       <= (pwr == PWR_NORMAL);
      hold.flip        <= ~hold.flip;
    end
  end

  always_comb begin
    next_frame = frame;
    // Counter saturates once the dual read is over
    if (frame.cnt != LAST_EDGE) begin
      next_frame.cnt = frame.cnt + 6'h01;
    end
    next_frame.ended = (next_frame.cnt == LAST_EDGE);
    next_frame.dout_first = hold.valid &
      frame_bit(next_frame.cnt, hold.word_first,
                hold.word_second);
    next_frame.dout_second = hold.valid &
      frame_bit(next_frame.cnt, hold.word_second,
                hold.word_first);
  end

  // Only falling edges advance the frame, so an early rise is
  // harmless; a fall racing the select fall still sees the clear
  always_ff @(negedge link.adc_serial_clock or posedge frame_clr) begin
    if (frame_clr) begin
      frame <= '0;
    end else begin
      frame <= next_frame;
    end
  end

  // Sampler returns to track on the rise after the 13th fall
  always_ff @(posedge link.adc_serial_clock or posedge frame_clr) begin
    if (frame_clr) begin
      track <= 1'b0;
    end else if (frame.cnt >= TRACK_EDGE) begin
      track <= 1'b1;
    end
  end

  assign sampler_hold    = ~link.cs_b & ~track;
  assign link.first_o    = frame.dout_first;
  assign link.second_o   = frame.dout_second;
  // First leading zero appears as soon as select falls
  assign link.first_oe   = ~link.cs_b & ~frame.ended;
  assign link.second_oe  = ~link.cs_b & ~frame.ended;

  // Power state is decided by where in the frame select rose
  always_comb begin
    next_pwr = pwr;
    if (frame.cnt >= PD_HI) begin
      next_pwr = PWR_NORMAL;
    end else if (frame.cnt >= PD_LO) begin
      if (pwr == PWR_NORMAL) begin
        next_pwr = PWR_PARTIAL;
      end else begin
        next_pwr = PWR_FULL;
      end
    end
  end

  // Reads the count before the same select rise clears it
  always_ff @(posedge link.cs_b or negedge rst_b) begin
    if (!rst_b) begin
      pwr <= PWR_NORMAL;
    end else begin
      pwr <= next_pwr;
    end
  end

  // Into sys_clk: three stages, update only when last two agree
  always_comb begin
    next_sys = sys;
    next_sys.pwr_s1 = pwr;
    next_sys.pwr_s2 = sys.pwr_s1;
    next_sys.pwr_s3 = sys.pwr_s2;
    if (sys.pwr_s2 == sys.pwr_s3) begin
      next_sys.power_state = sys.pwr_s3;
    end
    next_sys.tog = {sys.tog[1:0], hold.flip};
    next_sys.sample_taken = 1'b0;
    if (sys.tog[1] == sys.tog[2] && sys.tog[2] != sys.tog_seen) begin
      next_sys.tog_seen = sys.tog[2];
      next_sys.sample_taken = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  assign power_state  = sys.power_state;
  assign sample_taken = sys.sample_taken;

endmodule

// >>> hw/dasr_host.sv
// Host end: drives select and the divided serial clock, shifts in data
`timescale 1ns/1ps
`include "dasr_map.svh"
module dasr_host #(
  parameter int SCLK_HALF     = `DASR_SCLK_HALF_CYC,
  parameter int QUIET_CYC     = `DASR_QUIET_CYC,
  parameter int FULL_WAKE_CYC = `DASR_NS_TO_CYC(`DASR_FULL_WAKE_NS),
  parameter int PART_WAKE_CYC = `DASR_NS_TO_CYC(`DASR_PART_WAKE_NS),
  parameter int DWELL_CYC     = `DASR_NS_TO_CYC(`DASR_PART_DWELL_NS)
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  dasr_link_if.host                   link,
  input  wire logic                   start,
  input  wire logic [`DASR_CNT_W-1:0] edges,
  input  dasr_pkg::dasr_wake_t        wake_kind,
  output logic                        ready,
  output logic                        done,
  output logic [`DASR_RX_W-1:0]       word_first,
  output logic [`DASR_RX_W-1:0]       word_second
);
  import dasr_pkg::*;

  // Below five, bit 0 is taken before the data sync has settled
  localparam logic [7:0]  HALF_M1  = 8'(SCLK_HALF - 1);
  localparam logic [7:0]  QUIET_M1 = 8'(QUIET_CYC - 1);
  localparam logic [19:0] FULL_W   = 20'(FULL_WAKE_CYC);
  localparam logic [19:0] PART_W   = 20'(PART_WAKE_CYC);
  localparam logic [15:0] DWELL    = 16'(DWELL_CYC);
  localparam logic [`DASR_CNT_W-1:0] LONG =
    `DASR_CNT_W'(`DASR_LONG_EDGES);
  localparam logic [`DASR_CNT_W-1:0] PD_LO =
    `DASR_CNT_W'(`DASR_PD_LO);
  localparam logic [`DASR_CNT_W-1:0] PD_HI =
    `DASR_CNT_W'(`DASR_PD_HI);

  dasr_host_t s;
  dasr_host_t n;
  logic [`DASR_CNT_W-1:0] next_edge;

  always_comb begin
    n = s;
    n.done = 1'b0;
    next_edge = s.edge_n + 6'h01;
    // Data lines cross in on three stages; a level counts once
    // the second and third agree
    n.sa = {s.sa[1:0], link.data_out_first};
    n.sb = {s.sb[1:0], link.data_out_second};
    if (s.sa[1] == s.sa[2]) begin
      n.a_val = s.sa[2];
    end
    if (s.sb[1] == s.sb[2]) begin
      n.b_val = s.sb[2];
    end
    if (s.wake_cnt != 20'h00000) begin
      n.wake_cnt = s.wake_cnt - 20'h00001;
    end
    if (s.dwell != 16'hFFFF) begin
      n.dwell = s.dwell + 16'h0001;
    end
    case (s.st)
      H_IDLE: begin
        // Select falls while the clock is high, never on a fall
        if (!s.primed || start) begin
          n.cs_b   = 1'b0;
          n.div    = HALF_M1;
          n.edge_n = '0;
          n.rx_a   = '0;
          n.rx_b   = '0;
          n.ready  = 1'b0;
          n.primed = 1'b1;
          // First frame after reset is a full dummy
          n.target = !s.primed ? LONG :
                     (edges == '0) ? 6'h01 : edges;
          // Wake time runs from the select fall
          if (s.primed && wake_kind == WAKE_FULL) begin
            n.wake_cnt = FULL_W;
          end else if (s.primed && wake_kind == WAKE_PARTIAL) begin
            // Short dwell voids the quick wake; be conservative
            n.wake_cnt = (s.dwell >= DWELL) ? PART_W : FULL_W;
          end else begin
            n.wake_cnt = '0;
          end
          n.st = H_RUN;
        end
      end
      H_RUN: begin
        if (s.div != 8'h00) begin
          n.div = s.div - 8'h01;
        end else begin
          n.div  = HALF_M1;
          n.sclk = ~s.sclk;
          if (s.sclk) begin
            // Bit is stable a full half period before each fall
            n.rx_a   = {s.rx_a[`DASR_RX_W-2:0], s.a_val};
            n.rx_b   = {s.rx_b[`DASR_RX_W-2:0], s.b_val};
            n.edge_n = next_edge;
            if (next_edge == s.target) begin
              n.st = H_TAIL;
            end
          end
        end
      end
      H_TAIL: begin
        if (s.div != 8'h00) begin
          n.div = s.div - 8'h01;
        end else begin
          n.sclk   = 1'b1;
          n.cs_b   = 1'b1;
          n.div    = QUIET_M1;
          n.word_a = s.rx_a;
          n.word_b = s.rx_b;
          n.done   = 1'b1;
          // Abort inside the window starts a power-down dwell
          if (s.target >= PD_LO && s.target < PD_HI) begin
            n.dwell = '0;
          end
          n.st = H_QUIET;
        end
      end
      H_QUIET: begin
        if (s.div != 8'h00) begin
          n.div = s.div - 8'h01;
        end else if (s.wake_cnt == 20'h00000) begin
          n.ready = 1'b1;
          n.st    = H_IDLE;
        end
      end
      default: begin
        n.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s       <= '0;
      s.cs_b  <= 1'b1;
      s.sclk  <= 1'b1;
      s.sa    <= 3'h7;
      s.sb    <= 3'h7;
      s.dwell <= 16'hFFFF;
    end else begin
      s <= n;
    end
  end

  assign link.cs_b             = s.cs_b;
  assign link.adc_serial_clock = s.sclk;
  assign ready                 = s.ready;
  assign done                  = s.done;
  assign word_first            = s.word_a;
  assign word_second           = s.word_b;

endmodule

// >>> test/dasr_link_asserts.sv
// Link checker for the dual ADC serial readout
`timescale 1ns/1ps
module dasr_link_asserts #(
  parameter int FRAME_CLKS = 16
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic adc_serial_clock,
  input wire logic first_o,
  input wire logic first_oe,
  input wire logic second_o,
  input wire logic second_oe,
  input wire logic data_out_first,
  input wire logic data_out_second
);
  logic       sclk_q;
  logic [5:0] cnt;
  logic       calm;
  logic       zpos;

  // Serial clock is a sys_clk register, so sampling it here is exact
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_q <= 1'b1;
      cnt    <= 6'h00;
    end else begin
      sclk_q <= adc_serial_clock;
      if (cs_b) begin
        cnt <= 6'h00;
      end else if (sclk_q && !adc_serial_clock && cnt != 6'h3F) begin
        cnt <= cnt + 6'h01;
      end
    end
  end

  // No edge in this sample, so cnt is current
  assign calm = !cs_b && (sclk_q == adc_serial_clock);
  assign zpos = cnt < 6'h02 || (cnt >= 6'h0E && cnt < FRAME_CLKS + 2)
                || cnt >= FRAME_CLKS + 14;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_start_drive;
    $fell(cs_b) |-> first_oe && second_oe && !first_o && !second_o;
  endproperty
  a_start_drive: assert property (p_start_drive)
    else $error("lines not driven low at select fall");
  property p_released;
    cs_b |-> !first_oe && !second_oe && data_out_first && data_out_second;
  endproperty
  a_released: assert property (p_released)
    else $error("line driven while deselected");
  property p_dual_end;
    calm && cnt >= 6'h20 |-> !first_oe && !second_oe;
  endproperty
  a_dual_end: assert property (p_dual_end)
    else $error("line driven after 32 falls");
  property p_drive;
    calm && cnt < 6'h20 |-> first_oe && second_oe;
  endproperty
  a_drive: assert property (p_drive)
    else $error("line released inside frame");
  property p_zeros;
    calm && first_oe && zpos |-> !first_o && !second_o;
  endproperty
  a_zeros: assert property (p_zeros)
    else $error("zero bit slot not zero");
  property p_bit_stable;
    first_oe && $stable(cs_b) && !(sclk_q && !adc_serial_clock)
      |-> $stable(first_o) && $stable(second_o);
  endproperty
  a_bit_stable: assert property (p_bit_stable)
    else $error("data changed off a falling edge");
  property p_clk_idle;
    cs_b && $past(cs_b) |-> adc_serial_clock;
  endproperty
  a_clk_idle: assert property (p_clk_idle)
    else $error("serial clock moved outside frame");
  property p_first_gap;
    $fell(cs_b) |-> adc_serial_clock [*3];
  endproperty
  a_first_gap: assert property (p_first_gap)
    else $error("clock fell too close to select fall");
endmodule

// >>> test/dual_adc_serial_readout_tb_top.sv
// Testbench joining host and ADC ends of the serial readout
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) \
  begin \
    n_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("ERROR %0t: got %h want %h", $time, got, exp); \
    end \
  end
module dual_adc_serial_readout_tb_top;
  import dasr_pkg::*;
  localparam int FRAME_CLKS = 16;
  logic        sys_clk;
  logic        rst_b;
  logic        start;
  logic        ready;
  logic        done;
  logic        sampler_hold;
  logic        sample_taken;
  logic [5:0]  edges;
  logic [11:0] analog_first;
  logic [11:0] analog_second;
  logic [31:0] word_first;
  logic [31:0] word_second;
  logic [31:0] r;
  dasr_wake_t  wake_kind;
  dasr_pwr_t   power_state;
  int          err_total;
  int          n_checks;
  int          seed;
  int          n_cs;
  int          n_samp;
  int          hcnt;
  int          plan [13] = '{16, 14, 32, 34, 2, 9, 1, 10, 5, 1, 12, 13, 15};

  dasr_link_if link ();
  // Wake counts shortened so power-up waits stay brief; half period
  // kept above four so the first zero clears the data synchroniser
  dasr_host #(.SCLK_HALF(6), .FULL_WAKE_CYC(50), .PART_WAKE_CYC(10),
              .DWELL_CYC(40)) dasr_host_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link), .start(start),
    .edges(edges), .wake_kind(wake_kind), .ready(ready), .done(done),
    .word_first(word_first), .word_second(word_second));
  dasr_adc #(.FRAME_CLKS(FRAME_CLKS)) dasr_adc_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .link(link),
    .analog_first(analog_first), .analog_second(analog_second),
    .power_state(power_state), .sampler_hold(sampler_hold),
    .sample_taken(sample_taken));
  dasr_link_asserts #(.FRAME_CLKS(FRAME_CLKS)) dasr_link_asserts_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .cs_b(link.cs_b),
    .adc_serial_clock(link.adc_serial_clock), .first_o(link.first_o),
    .first_oe(link.first_oe), .second_o(link.second_o),
    .second_oe(link.second_oe), .data_out_first(link.data_out_first),
    .data_out_second(link.data_out_second));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  always @(negedge link.cs_b) begin
    n_cs++;
    hcnt = 0;
    #1 `CHECK_EQ(sampler_hold, 1'b1)
  end
  always @(negedge link.adc_serial_clock) begin
    if (!link.cs_b) hcnt++;
  end
  // Select may rise with this edge; look after it settles
  always @(posedge link.adc_serial_clock) begin
    #1;
    if (link.cs_b === 1'b0) `CHECK_EQ(sampler_hold, hcnt < 13)
  end
  always @(posedge sys_clk) begin
    if (sample_taken === 1'b1) n_samp++;
  end

  function automatic logic [31:0] exp_word(int n, logic [11:0] own,
                                           logic [11:0] oth, logic ok);
    logic [31:0] w;
    int          j;
    w = 32'h0;
    for (int k = 0; k < n; k++) begin
      j = k % 16;
      if (k >= 32) w = {w[30:0], 1'b1};
      else if (!ok || j < 2 || j > 13) w = {w[30:0], 1'b0};
      else w = {w[30:0], (k < 16) ? own[13-j] : oth[13-j]};
    end
    return w;
  endfunction

  function automatic dasr_pwr_t next_pwr(dasr_pwr_t p, int n);
    if (n < 2) return p;
    if (n < 10) return (p == PWR_NORMAL) ? PWR_PARTIAL : PWR_FULL;
    return PWR_NORMAL;
  endfunction

  task automatic wait_ready;
    int t;
    t = 0;
    while (ready !== 1'b1 && t < 4000) begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= 4000) err_total++;
  endtask

  task automatic run_frame(input int n, input dasr_wake_t wk);
    logic [31:0] m;
    logic [31:0] ea;
    logic [31:0] eb;
    dasr_pwr_t   p0;
    logic        ok;
    int          t;
    wait_ready();
    r = $random(seed);
    analog_first = r[11:0];
    analog_second = r[27:16];
    edges = n[5:0];
    wake_kind = wk;
    p0 = power_state;
    ok = (p0 == PWR_NORMAL);
    start = 1'b1;
    @(negedge sys_clk);
    start = 1'b0;
    t = 0;
    while (done !== 1'b1 && t < 2000) begin
      @(negedge sys_clk);
      t++;
    end
    if (t >= 2000) err_total++;
    m = (n >= 32) ? 32'hFFFFFFFF : (32'h1 << n) - 32'h1;
    ea = exp_word(n, analog_first, analog_second, ok) & m;
    eb = exp_word(n, analog_second, analog_first, ok) & m;
    `CHECK_EQ(word_first & m, ea)
    `CHECK_EQ(word_second & m, eb)
    wait_ready();
    `CHECK_EQ(power_state, next_pwr(p0, n))
  endtask

  task finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    finish_test();
  end

  initial begin
    seed = 45;
    rst_b = 1'b0;
    start = 1'b0;
    edges = 6'h10;
    wake_kind = WAKE_NONE;
    analog_first = 12'h000;
    analog_second = 12'h000;
    repeat (5) @(negedge sys_clk);
    rst_b = 1'b1;
    wait_ready();
    `CHECK_EQ(power_state, PWR_NORMAL)
    foreach (plan[i]) run_frame(plan[i], WAKE_NONE);
    run_frame(3, WAKE_NONE);
    run_frame(4, WAKE_NONE);
    run_frame(16, WAKE_FULL);
    run_frame(16, WAKE_NONE);
    run_frame(6, WAKE_NONE);
    run_frame(16, WAKE_PARTIAL);
    repeat (20) begin
      r = $random(seed);
      run_frame(10 + r[4:0], dasr_wake_t'(r[6:5] == 2'h3 ? 2'h0 : r[6:5]));
    end
    run_frame(2, WAKE_NONE);
    run_frame(2, WAKE_NONE);
    // Reset while fully powered down must bring back normal mode
    rst_b = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHECK_EQ({link.cs_b, power_state}, {1'b1, PWR_NORMAL})
    rst_b = 1'b1;
    run_frame(14, WAKE_NONE);
    `CHECK_EQ(n_samp, n_cs)
    finish_test();
  end
endmodule
